// file: near_limit_check.sv
// Shared constants and the near-limit comparator used by the thermal and regen warnings
`default_nettype none

package drive_fault_pkg;
	// --------------------------------------------------------------
	// Bus geometry
	// --------------------------------------------------------------
	localparam int          AW = 8;
	localparam int          DW = 16;
	localparam int          NF = 10;
	// --------------------------------------------------------------
	// Register byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0]  ADDR_WARN      = 8'h00;
	localparam logic [7:0]  ADDR_MODEL     = 8'h04;
	localparam logic [7:0]  ADDR_DIGIN     = 8'h08;
	localparam logic [7:0]  ADDR_PSTAGE    = 8'h0C;
	localparam logic [7:0]  ADDR_IDENT     = 8'h10;
	localparam logic [7:0]  ADDR_GENSTAT   = 8'h14;
	localparam logic [7:0]  ADDR_CLEAR     = 8'h18;
	localparam logic [7:0]  ADDR_OFFA_LIM  = 8'h1C;
	localparam logic [7:0]  ADDR_OFFB_LIM  = 8'h20;
	localparam logic [7:0]  ADDR_I2T_LVL   = 8'h24;
	localparam logic [7:0]  ADDR_IT_LVL    = 8'h28;
	localparam logic [7:0]  ADDR_MOTOR_MAX = 8'h2C;
	localparam logic [7:0]  ADDR_BRIDGE_MAX = 8'h30;
	localparam logic [7:0]  ADDR_REGEN_MAX = 8'h34;
	localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h38;
	localparam logic [7:0]  ADDR_IRQ_EN    = 8'h3C;
	localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h40;
	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int          PS_ENABLE_BIT  = 7;
	localparam int          PS_FAULT_LSB   = 0;
	localparam int          PS_FAULT_W     = 4;
	localparam int          FLT_MODEL_W    = 6;
	localparam int          FLT_INIT       = 0;
	localparam int          FLT_PROG       = 1;
	localparam int          FLT_OVERRUN    = 5;
	localparam int          FLT_SC_TOP     = 9;
	localparam int          GEN_TYPE1_BIT  = 0;
	localparam int          GEN_EXC_BIT    = 1;
	localparam int          GEN_INIT_BIT   = 2;
	localparam int          CLEAR_CMD_BIT  = 0;
	localparam int          IRQ_W          = 4;
	localparam logic [15:0] LIMIT_RESET    = 16'hFFFF;
	localparam logic [1:0]  CLEAR_LVL_MAX  = 2'h2;
	localparam logic [19:0] FAULT_LVL_DEF  = 20'hAAAAA;
	// Within ten percent: value * 10 >= max * 9
	localparam logic [3:0]  NEAR_DEN       = 4'hA;
	localparam logic [3:0]  NEAR_NUM       = 4'h9;
endpackage

module near_limit_check
	import drive_fault_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Compared quantities
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] max_value,
	// Registered result
	output var  logic         near
);
	localparam int SW = W + 4;

	logic [SW-1:0] scaled_value;
	logic [SW-1:0] scaled_max;

	assign scaled_value = SW'(value) * SW'(NEAR_DEN);
	assign scaled_max   = SW'(max_value) * SW'(NEAR_NUM);

	always_ff @(posedge clk) begin
		if (rst) begin
			near <= 1'b0;
		end else begin
			near <= scaled_value >= scaled_max;
		end
	end
endmodule

`default_nettype wire

// file: drive_fault_status_monitor.sv
// Servo drive status and fault reporting register bank
// Operation
// - Phase A offset flag faults while measured offset exceeds programmed limit.
// - Phase B offset flag faults while measured offset exceeds its limit.
// - Current-squared-time warning while that measure exceeds its warning level.
// - Current-time warning while that measure exceeds its warning level.
// - Motor thermal warning when winding temperature within ten percent of maximum.
// - Bridge thermal warning when heatsink temperature within ten percent of maximum.
// - Regen warning when resistor power within ten percent of continuous rating.
// - Limit switch warning when either travel limit input is active.
// - Model initialisation fault on failed init or parameter access.
// - Separate programming, dynamic, static position and velocity fault flags.
// - Model overrun fault when an execution exceeds its time limit.
// - Input byte: bit 0 hardware enable, bits 1-7 digital inputs 1-7.
// - Power byte: enable state bit 7, short top bit 3, bottom bit 2.
// - Power byte: regeneration fault bit 1, dead-time fault bit 0.
// - A readable identifier names the fitted power stage.
// - Clear command clears every latched fault of level 2 or lower except the model initialisation fault and init-time faults.
// - Init-time and processor exception faults survive the clear command.
// - Type-1 general status bit shows a non-clearable fault has occurred.
`default_nettype none

module drive_fault_status_monitor
	import drive_fault_pkg::*;
#(
	parameter logic [7:0]      POWER_STAGE_ID = 8'h5A, // Arbitrary value
	parameter logic [2*NF-1:0] FAULT_LEVELS   = FAULT_LVL_DEF
) (
	// Clock and reset
	input  wire logic          MCLK,
	input  wire logic          SRST,
	// Register port
	input  wire logic [AW-1:0] ADDR,
	input  wire logic [DW-1:0] WDATA,
	input  wire logic          WR,
	input  wire logic          RD,
	output var  logic [DW-1:0] RDATA,
	output var  logic          IRQ,
	// Measurements from drive sensing, same clock
	input  wire logic [DW-1:0] OFFSET_A_MEAS,
	input  wire logic [DW-1:0] OFFSET_B_MEAS,
	input  wire logic [DW-1:0] I2T_MEAS,
	input  wire logic [DW-1:0] IT_MEAS,
	input  wire logic [DW-1:0] MOTOR_TEMP,
	input  wire logic [DW-1:0] BRIDGE_TEMP,
	input  wire logic [DW-1:0] REGEN_POWER,
	// Asynchronous pins
	input  wire logic [7:0]    DIG_IN,
	input  wire logic          LIMIT_CW,
	input  wire logic          LIMIT_CCW,
	// Fault events, one-cycle pulses, same clock
	input  wire logic          MODEL_INIT_FAIL,
	input  wire logic          MODEL_PROG_ERR,
	input  wire logic          MODEL_DYN_POS_ERR,
	input  wire logic          MODEL_STAT_POS_ERR,
	input  wire logic          MODEL_VEL_ERR,
	input  wire logic          MODEL_OVERRUN,
	input  wire logic          PWM_DEADTIME_FAULT,
	input  wire logic          REGEN_FAULT,
	input  wire logic          SHORT_BOTTOM_FAULT,
	input  wire logic          SHORT_TOP_FAULT,
	input  wire logic          CPU_EXCEPTION,
	// Drive state, same clock
	input  wire logic          DRIVE_ENABLED,
	input  wire logic          INIT_DONE
);
	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	logic [DW-1:0]    off_a_limit;
	logic [DW-1:0]    off_b_limit;
	logic [DW-1:0]    i2t_level;
	logic [DW-1:0]    it_level;
	logic [DW-1:0]    motor_max;
	logic [DW-1:0]    bridge_max;
	logic [DW-1:0]    regen_max;
	logic [7:0]       warn;
	logic [3:0]       level_flag;
	logic             limit_flag;
	logic [7:0]       warn_prev;
	logic             motor_near;
	logic             bridge_near;
	logic             regen_near;
	logic [9:0]       pin_meta;
	logic [9:0]       pin_sync;
	logic [7:0]       dig_in;
	logic             limit_active;
	logic [NF-1:0]    fault_set;
	logic [NF-1:0]    fault_lat;
	logic [NF-1:0]    fault_lock;
	logic             exc_fault;
	logic             type1;
	logic             clear_cmd;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_event;
	logic [DW-1:0]    next_rdata;

	assign fault_set = {SHORT_TOP_FAULT, SHORT_BOTTOM_FAULT, REGEN_FAULT, PWM_DEADTIME_FAULT,
		MODEL_OVERRUN, MODEL_VEL_ERR, MODEL_STAT_POS_ERR, MODEL_DYN_POS_ERR,
		MODEL_PROG_ERR, MODEL_INIT_FAIL};
	assign clear_cmd = WR && (ADDR == ADDR_CLEAR) && WDATA[CLEAR_CMD_BIT];

	// --------------------------------------------------------------
	// Programmable limits
	// --------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			off_a_limit <= LIMIT_RESET;
			off_b_limit <= LIMIT_RESET;
			i2t_level   <= LIMIT_RESET;
			it_level    <= LIMIT_RESET;
			motor_max   <= LIMIT_RESET;
			bridge_max  <= LIMIT_RESET;
			regen_max   <= LIMIT_RESET;
		end else if (WR) begin
			unique case (ADDR)
				ADDR_OFFA_LIM:   off_a_limit <= WDATA;
				ADDR_OFFB_LIM:   off_b_limit <= WDATA;
				ADDR_I2T_LVL:    i2t_level   <= WDATA;
				ADDR_IT_LVL:     it_level    <= WDATA;
				ADDR_MOTOR_MAX:  motor_max   <= WDATA;
				ADDR_BRIDGE_MAX: bridge_max  <= WDATA;
				ADDR_REGEN_MAX:  regen_max   <= WDATA;
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pin_meta <= 10'h000;
			pin_sync <= 10'h000;
		end else begin
			pin_meta <= {LIMIT_CCW, LIMIT_CW, DIG_IN};
			pin_sync <= pin_meta;
		end
	end

	assign dig_in       = pin_sync[7:0];
	assign limit_active = pin_sync[8] | pin_sync[9];

	// --------------------------------------------------------------
	// Warning flags
	// --------------------------------------------------------------
	near_limit_check #(
		.W (DW)
	) u_motor_near (
		.clk       (MCLK),
		.rst       (SRST),
		.value     (MOTOR_TEMP),
		.max_value (motor_max),
		.near      (motor_near)
	);

	near_limit_check #(
		.W (DW)
	) u_bridge_near (
		.clk       (MCLK),
		.rst       (SRST),
		.value     (BRIDGE_TEMP),
		.max_value (bridge_max),
		.near      (bridge_near)
	);

	near_limit_check #(
		.W (DW)
	) u_regen_near (
		.clk       (MCLK),
		.rst       (SRST),
		.value     (REGEN_POWER),
		.max_value (regen_max),
		.near      (regen_near)
	);

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			level_flag <= 4'h0;
			limit_flag <= 1'b0;
		end else begin
			level_flag[0] <= OFFSET_A_MEAS > off_a_limit;
			level_flag[1] <= OFFSET_B_MEAS > off_b_limit;
			level_flag[2] <= I2T_MEAS > i2t_level;
			level_flag[3] <= IT_MEAS > it_level;
			limit_flag    <= limit_active;
		end
	end

	// Comparator stages are already registered
	assign warn = {limit_flag, regen_near, bridge_near, motor_near, level_flag};

	// --------------------------------------------------------------
	// Latched faults
	// --------------------------------------------------------------
	// Set wins over clear; init fault and init-time faults never clear
	for (genvar i = 0; i < NF; i++) begin : g_fault
		always_ff @(posedge MCLK) begin
			if (SRST) begin
				fault_lat[i]  <= 1'b0;
				fault_lock[i] <= 1'b0;
			end else begin
				if (fault_set[i]) begin
					fault_lat[i] <= 1'b1;
				end else if (clear_cmd && !fault_lock[i] && (i != FLT_INIT)
						&& (FAULT_LEVELS[2*i +: 2] <= CLEAR_LVL_MAX)) begin
					fault_lat[i] <= 1'b0;
				end
				if (fault_set[i] && !INIT_DONE) begin
					fault_lock[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			exc_fault <= 1'b0;
			type1     <= 1'b0;
		end else begin
			if (CPU_EXCEPTION) begin
				exc_fault <= 1'b1;
			end
			type1 <= exc_fault | fault_lat[FLT_INIT] | (|(fault_lat & fault_lock));
		end
	end

	// --------------------------------------------------------------
	// Interrupts
	// --------------------------------------------------------------
	// Warning rises, new model fault, new power fault, non-clearable fault
	assign irq_event = {CPU_EXCEPTION | fault_set[FLT_INIT]
		| (!INIT_DONE && (|(fault_set & ~fault_lock))),
		|fault_set[NF-1:FLT_MODEL_W], |fault_set[FLT_MODEL_W-1:0],
		|(warn & ~warn_prev)};

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			warn_prev <= 8'h00;
			irq_stat  <= '0;
			irq_en    <= '0;
			IRQ       <= 1'b0;
		end else begin
			warn_prev <= warn;
			if (WR && ADDR == ADDR_IRQ_EN) begin
				irq_en <= WDATA[IRQ_W-1:0];
			end
			if (WR && ADDR == ADDR_IRQ_CLR) begin
				irq_stat <= (irq_stat & ~WDATA[IRQ_W-1:0]) | irq_event;
			end else begin
				irq_stat <= irq_stat | irq_event;
			end
			IRQ <= |(irq_stat & irq_en);
		end
	end

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	always_comb begin
		next_rdata = '0;
		unique case (ADDR)
			ADDR_WARN:       next_rdata = {8'h00, warn};
			ADDR_MODEL:      next_rdata = {10'h000, fault_lat[FLT_MODEL_W-1:0]};
			ADDR_DIGIN:      next_rdata = {8'h00, dig_in};
			ADDR_PSTAGE: begin
				next_rdata[PS_ENABLE_BIT] = DRIVE_ENABLED;
				next_rdata[PS_FAULT_LSB +: PS_FAULT_W] = fault_lat[NF-1:FLT_MODEL_W];
			end
			ADDR_IDENT:      next_rdata = {8'h00, POWER_STAGE_ID};
			ADDR_GENSTAT: begin
				next_rdata[GEN_TYPE1_BIT] = type1;
				next_rdata[GEN_EXC_BIT]   = exc_fault;
				next_rdata[GEN_INIT_BIT]  = INIT_DONE;
			end
			ADDR_OFFA_LIM:   next_rdata = off_a_limit;
			ADDR_OFFB_LIM:   next_rdata = off_b_limit;
			ADDR_I2T_LVL:    next_rdata = i2t_level;
			ADDR_IT_LVL:     next_rdata = it_level;
			ADDR_MOTOR_MAX:  next_rdata = motor_max;
			ADDR_BRIDGE_MAX: next_rdata = bridge_max;
			ADDR_REGEN_MAX:  next_rdata = regen_max;
			ADDR_IRQ_STAT:   next_rdata = {12'h000, irq_stat};
			ADDR_IRQ_EN:     next_rdata = {12'h000, irq_en};
			default:         next_rdata = '0;
		endcase
	end

	// Data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			RDATA <= '0;
		end else begin
			RDATA <= RD ? next_rdata : '0;
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SRST);

	AST_OFFSET_A: assert property ((OFFSET_A_MEAS > off_a_limit) |=> warn[0])
		else $error("Phase A offset flag missed");
	AST_OFFSET_B: assert property (!(OFFSET_B_MEAS > off_b_limit) |=> !warn[1])
		else $error("Phase B offset flag raised without cause");
	AST_I2T: assert property ((I2T_MEAS > i2t_level) ##1 (I2T_MEAS > i2t_level) |=> warn[2])
		else $error("Current-squared-time warning missed");
	AST_IT: assert property (warn[3] |-> $past(IT_MEAS) > $past(it_level))
		else $error("Current-time warning without cause");
	AST_NEAR: assert property ((MOTOR_TEMP == motor_max) && (motor_max != '0) |=> motor_near)
		else $error("Motor thermal warning missed at maximum");
	AST_LIMIT: assert property (limit_active |=> warn[7])
		else $error("Limit switch warning missed");
	AST_OVERRUN: assert property (MODEL_OVERRUN |=> fault_lat[FLT_OVERRUN]
		##1 (fault_lat[FLT_OVERRUN] || $past(clear_cmd)))
		else $error("Overrun fault not latched");
	AST_DIGIN: assert property (RD && ADDR == ADDR_DIGIN |=> RDATA == {8'h00, $past(dig_in)})
		else $error("Digital input byte wrong");
	AST_PSTAGE: assert property (RD && ADDR == ADDR_PSTAGE |=>
		RDATA[3] == $past(fault_lat[FLT_SC_TOP]) && RDATA[7] == $past(DRIVE_ENABLED))
		else $error("Power stage byte wrong");
	AST_CLEAR: assert property (clear_cmd && !fault_set[FLT_PROG] && !fault_lock[FLT_PROG]
		&& FAULT_LEVELS[2*FLT_PROG +: 2] <= CLEAR_LVL_MAX |=> !fault_lat[FLT_PROG])
		else $error("Clearable fault survived clear");
	AST_KEEP_INIT: assert property (fault_lat[FLT_INIT] |=> fault_lat[FLT_INIT])
		else $error("Initialisation fault was cleared");
	AST_TYPE1: assert property ($rose(exc_fault) |=> type1 ##1 type1)
		else $error("Type-1 bit missing after exception");
	AST_KEEP_LOCKED: assert property (clear_cmd |=> (fault_lock & ~fault_lat) == '0)
		else $error("Locked fault was cleared");
	AST_EXC: assert property (CPU_EXCEPTION |=> exc_fault)
		else $error("Exception not latched");
	AST_TYPE1_LOCK: assert property (|(fault_lat & fault_lock) |=> type1)
		else $error("Type-1 bit missing after locked fault");
	AST_IDENT: assert property (RD && ADDR == ADDR_IDENT |=> RDATA == {8'h00, POWER_STAGE_ID})
		else $error("Power stage identifier wrong");

	COV_CLEAR: cover property (fault_lat[FLT_PROG] ##1 clear_cmd ##1 !fault_lat[FLT_PROG]);
	COV_LOCKED: cover property (fault_lock[FLT_PROG] && clear_cmd ##1 fault_lat[FLT_PROG]);
	COV_IRQ: cover property ($rose(IRQ));
	COV_THERMAL: cover property ($rose(motor_near) ##[1:20] $rose(bridge_near));
endmodule

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the drive fault and status register bank
`default_nettype none

module testbench
	import drive_fault_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic            MCLK, SRST, WR, RD, IRQ, LIMIT_CW, LIMIT_CCW, DRIVE_ENABLED, INIT_DONE;
	logic [AW-1:0]   ADDR;
	logic [DW-1:0]   WDATA, RDATA;
	logic [7:0]      DIG_IN;
	logic [DW-1:0]   meas [7];
	logic [10:0]     ev;
	int              err_count, n_tests, cycles;
	localparam logic [7:0]      STAGE_ID = 8'hC3; // Arbitrary value
	// Velocity fault at level 3: the clear must spare it
	localparam logic [2*NF-1:0] LEVELS   = 20'hAABAA;

	drive_fault_status_monitor #(
		.POWER_STAGE_ID (STAGE_ID),
		.FAULT_LEVELS   (LEVELS)
	) i_drive_fault_status_monitor (
		.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .IRQ(IRQ), .OFFSET_A_MEAS(meas[0]), .OFFSET_B_MEAS(meas[1]),
		.I2T_MEAS(meas[2]), .IT_MEAS(meas[3]), .MOTOR_TEMP(meas[4]),
		.BRIDGE_TEMP(meas[5]), .REGEN_POWER(meas[6]), .DIG_IN(DIG_IN),
		.LIMIT_CW(LIMIT_CW), .LIMIT_CCW(LIMIT_CCW), .MODEL_INIT_FAIL(ev[0]),
		.MODEL_PROG_ERR(ev[1]), .MODEL_DYN_POS_ERR(ev[2]), .MODEL_STAT_POS_ERR(ev[3]),
		.MODEL_VEL_ERR(ev[4]), .MODEL_OVERRUN(ev[5]), .PWM_DEADTIME_FAULT(ev[6]),
		.REGEN_FAULT(ev[7]), .SHORT_BOTTOM_FAULT(ev[8]), .SHORT_TOP_FAULT(ev[9]),
		.CPU_EXCEPTION(ev[10]), .DRIVE_ENABLED(DRIVE_ENABLED), .INIT_DONE(INIT_DONE)
	);

	// ------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ------------------------------------------------------------
	initial begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end

	always @(posedge MCLK) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count = err_count + 1;
			$display("[ERR] %0t timeout", $time);
			end_sim();
		end
	end

	task automatic end_sim();
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		@(negedge MCLK);
		chk(RDATA, e, "read");
		@(posedge MCLK);
	endtask

	task automatic pulse(input int i);
		@(posedge MCLK);
		ev[i] <= 1'b1;
		@(posedge MCLK);
		ev[i] <= 1'b0;
		repeat (3) @(posedge MCLK);
	endtask

	task automatic reset_dut();
		@(posedge MCLK);
		SRST <= 1'b1;
		repeat (8) @(posedge MCLK);
		SRST <= 1'b0;
	endtask

	task automatic settle();
		repeat (5) @(posedge MCLK);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_map();
		for (int i = 0; i < 7; i++)
			rd(ADDR_OFFA_LIM + 8'(4 * i), LIMIT_RESET);
		rd(ADDR_IDENT, {8'h00, STAGE_ID});
		rd(ADDR_IRQ_EN, 16'h0000);
		wr(ADDR_WARN, 16'h00FF);
		wr(8'h44, 16'hFFFF);
		rd(ADDR_WARN, 16'h0000);
		rd(8'h44, 16'h0000);
	endtask

	// Strictly greater trips, equal stays quiet
	task automatic t_levels();
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_OFFA_LIM + 8'(4 * i), 16'h0064);
			rd(ADDR_OFFA_LIM + 8'(4 * i), 16'h0064);
			meas[i] <= 16'h0064;
			settle();
			rd(ADDR_WARN, 16'h0000);
			meas[i] <= 16'h0065;
			settle();
			rd(ADDR_WARN, 16'(1 << i));
			meas[i] <= 16'h0000;
		end
	endtask

	// Ninety of a hundred is the first value inside the band
	task automatic t_near();
		for (int i = 4; i < 7; i++) begin
			wr(ADDR_OFFA_LIM + 8'(4 * i), 16'h0064);
			meas[i] <= 16'h0059;
			settle();
			rd(ADDR_WARN, 16'h0000);
			meas[i] <= 16'h005A;
			settle();
			rd(ADDR_WARN, 16'(1 << i));
			meas[i] <= 16'h0064;
			settle();
			rd(ADDR_WARN, 16'(1 << i));
			meas[i] <= 16'h0000;
		end
		settle();
	endtask

	task automatic t_pins();
		LIMIT_CW <= 1'b1;
		DIG_IN <= 8'hA5;
		settle();
		rd(ADDR_WARN, 16'h0080);
		rd(ADDR_DIGIN, 16'h00A5);
		LIMIT_CW <= 1'b0;
		LIMIT_CCW <= 1'b1;
		DIG_IN <= 8'h5A;
		settle();
		rd(ADDR_WARN, 16'h0080);
		rd(ADDR_DIGIN, 16'h005A);
		LIMIT_CCW <= 1'b0;
		settle();
		rd(ADDR_WARN, 16'h0000);
	endtask

	task automatic t_faults();
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			rd(ADDR_MODEL, 16'((2 << i) - 1));
		end
		for (int i = 0; i < 4; i++) begin
			pulse(6 + i);
			rd(ADDR_PSTAGE, 16'(8'h80 | ((2 << i) - 1)));
		end
		DRIVE_ENABLED <= 1'b0;
		settle();
		rd(ADDR_PSTAGE, 16'h000F);
		wr(ADDR_CLEAR, 16'h0001);
		settle();
		rd(ADDR_MODEL, 16'h0011);
		rd(ADDR_PSTAGE, 16'h0000);
		rd(ADDR_GENSTAT, 16'h0005);
		pulse(10);
		wr(ADDR_CLEAR, 16'h0001);
		settle();
		rd(ADDR_GENSTAT, 16'h0007);
		DRIVE_ENABLED <= 1'b1;
	endtask

	// A fault raised before initialisation ends must survive the clear
	task automatic t_init_lock();
		INIT_DONE <= 1'b0;
		reset_dut();
		pulse(2);
		INIT_DONE <= 1'b1;
		pulse(3);
		rd(ADDR_MODEL, 16'h000C);
		wr(ADDR_CLEAR, 16'h0001);
		settle();
		rd(ADDR_MODEL, 16'h0004);
		rd(ADDR_GENSTAT, 16'h0005);
	endtask

	task automatic t_irq();
		reset_dut();
		wr(ADDR_IRQ_EN, 16'h0002);
		rd(ADDR_IRQ_EN, 16'h0002);
		pulse(4);
		@(negedge MCLK);
		chk(16'(IRQ), 16'h0001, "irq high");
		rd(ADDR_IRQ_STAT, 16'h0002);
		wr(ADDR_IRQ_CLR, 16'h0002);
		settle();
		@(negedge MCLK);
		chk(16'(IRQ), 16'h0000, "irq cleared");
		pulse(7);
		rd(ADDR_IRQ_STAT, 16'h0004);
		@(negedge MCLK);
		chk(16'(IRQ), 16'h0000, "irq masked");
		wr(ADDR_IRQ_EN, 16'h0004);
		LIMIT_CW <= 1'b1;
		settle();
		@(negedge MCLK);
		chk(16'(IRQ), 16'h0001, "irq unmasked");
		pulse(10);
		rd(ADDR_IRQ_STAT, 16'h000D);
		LIMIT_CW <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		err_count = 0;
		n_tests = 0;
		cycles = 0;
		SRST = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = '0;
		WDATA = '0;
		DIG_IN = '0;
		LIMIT_CW = 1'b0;
		LIMIT_CCW = 1'b0;
		DRIVE_ENABLED = 1'b1;
		INIT_DONE = 1'b1;
		ev = '0;
		for (int i = 0; i < 7; i++)
			meas[i] = '0;
		repeat (8) @(posedge MCLK);
		SRST <= 1'b0;
		t_reset_map();
		t_levels();
		t_near();
		t_pins();
		t_faults();
		t_init_lock();
		t_irq();
		end_sim();
	end
endmodule

`default_nettype wire
